// ==== include/irq_trim_pkg.sv ====
package irq_trim_pkg;
    localparam logic [6:0] dev_addr          = 7'h60;
    localparam logic [7:0] addr_pin_config   = 8'h28;
    localparam logic [7:0] addr_irq_enable   = 8'h29;
    localparam logic [7:0] addr_pin_routing  = 8'h2a;
    localparam logic [7:0] addr_press_trim   = 8'h2b;
    localparam logic [7:0] addr_temp_trim    = 8'h2c;
    localparam logic [7:0] addr_alt_trim     = 8'h2d;
    localparam logic [7:0] reg_reset         = 8'h00;
    localparam logic [7:0] pin_config_mask   = 8'h33;
    localparam int         bit_a_polarity    = 5;
    localparam int         bit_a_drive_kind  = 4;
    localparam int         bit_b_polarity    = 1;
    localparam int         bit_b_drive_kind  = 0;
    localparam int         bit_sample_done   = 7;
    localparam int         bit_fifo          = 6;
    localparam int         bit_press_window  = 5;
    localparam int         bit_temp_window   = 4;
    localparam int         bit_press_limit   = 3;
    localparam int         bit_temp_limit    = 2;
    localparam int         bit_press_delta   = 1;
    localparam int         bit_temp_delta    = 0;
    localparam int         press_pa_per_lsb  = 4;
    localparam int         press_trim_shift  = 2;
    localparam int         temp_frac_bits    = 4;
    localparam int         press_width       = 20;
    localparam int         temp_width        = 12;
    localparam int         alt_width         = 20;
    localparam logic [3:0] bit_cnt_last      = 4'h8;
endpackage : irq_trim_pkg

// ==== verilog/irq_pin_driver.sv ====
`timescale 1ns/1ps
module irq_pin_driver (
    input  wire logic active,
    input  wire logic polarity,
    input  wire logic drive_kind,
    output logic      pin_o,
    output logic      pin_oe
);
    logic level;
    // active level chosen by polarity, open drain only pulls low
    assign level  = polarity ? active : ~active;
    assign pin_o  = drive_kind ? 1'b0 : level;
    assign pin_oe = drive_kind ? ~level : 1'b1;
endmodule : irq_pin_driver

// ==== verilog/irq_routing_offset_trim.sv ====
`timescale 1ns/1ps
module irq_routing_offset_trim (
    input  wire logic                                 clk,
    input  wire logic                                 reset_n,
    input  wire logic                                 scl_i,
    input  wire logic                                 sda_i,
    output logic                                      sda_o,
    output logic                                      sda_oe,
    input  wire logic [7:0]                           event_flags,
    input  wire logic [irq_trim_pkg::press_width-1:0] press_raw,
    input  wire logic [irq_trim_pkg::temp_width-1:0]  temp_raw,
    input  wire logic [irq_trim_pkg::alt_width-1:0]   alt_raw,
    output logic [irq_trim_pkg::press_width-1:0]      press_out,
    output logic [irq_trim_pkg::temp_width-1:0]       temp_out,
    output logic [irq_trim_pkg::alt_width-1:0]        alt_out,
    output logic                                      irq_pin_a_o,
    output logic                                      irq_pin_a_oe,
    output logic                                      irq_pin_b_o,
    output logic                                      irq_pin_b_oe
);
    import irq_trim_pkg::*;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_addr = 3'b001,
        st_ack  = 3'b010,
        st_rx   = 3'b011,
        st_tx   = 3'b100,
        st_mack = 3'b101
    } bus_state_t;

    typedef struct packed {
        logic [1:0]                 scl_s;
        logic [1:0]                 sda_s;
        logic                       scl_d;
        logic                       sda_d;
        bus_state_t                 st;
        logic [3:0]                 cnt;
        logic [7:0]                 sh;
        logic                       rd;
        logic                       have_ptr;
        logic                       ack_drv;
        logic [7:0]                 ptr;
        logic [7:0]                 pin_cfg;
        logic [7:0]                 irq_en;
        logic [7:0]                 routing;
        logic [7:0]                 p_trim;
        logic [7:0]                 t_trim;
        logic [7:0]                 a_trim;
        logic [press_width-1:0]     p_out;
        logic [temp_width-1:0]      t_out;
        logic [alt_width-1:0]       a_out;
        logic                       pa;
        logic                       pb;
    } state_t;

    state_t s_r, s_nxt;

    function automatic logic [7:0] read_reg(input state_t s, input logic [7:0] a);
        logic [7:0] v;
        v = reg_reset;
        if (a == addr_pin_config) v = s.pin_cfg;
        else if (a == addr_irq_enable) v = s.irq_en;
        else if (a == addr_pin_routing) v = s.routing;
        else if (a == addr_press_trim) v = s.p_trim;
        else if (a == addr_temp_trim) v = s.t_trim;
        else if (a == addr_alt_trim) v = s.a_trim;
        return v;
    endfunction : read_reg

    logic scl_rise, scl_fall, start_c, stop_c, scl_h, sda_h;
    logic [7:0] gated;
    assign scl_h    = s_r.scl_s[1];
    assign sda_h    = s_r.sda_s[1];
    assign scl_rise = scl_h & ~s_r.scl_d;
    assign scl_fall = ~scl_h & s_r.scl_d;
    assign start_c  = scl_h & s_r.scl_d & s_r.sda_d & ~sda_h;
    assign stop_c   = scl_h & s_r.scl_d & ~s_r.sda_d & sda_h;
    assign gated    = event_flags & s_r.irq_en;

    always_comb begin
        s_nxt = s_r;
        s_nxt.scl_s = {s_r.scl_s[0], scl_i};
        s_nxt.sda_s = {s_r.sda_s[0], sda_i};
        s_nxt.scl_d = scl_h;
        s_nxt.sda_d = sda_h;
        // routed OR per pin; bit order fixed by event_flags layout
        s_nxt.pa = |(gated & s_r.routing);
        s_nxt.pb = |(gated & ~s_r.routing);
        // trims applied to every result, current value used at once
        s_nxt.p_out = press_raw + press_width'({{(press_width-8){s_r.p_trim[7]}}, s_r.p_trim}
                      << press_trim_shift);
        s_nxt.t_out = temp_raw + {{(temp_width-8){s_r.t_trim[7]}}, s_r.t_trim};
        s_nxt.a_out = alt_raw + {{(alt_width-8){s_r.a_trim[7]}}, s_r.a_trim};
        if (start_c) begin
            s_nxt.st = st_addr;
            s_nxt.cnt = 4'h0;
            s_nxt.have_ptr = 1'b0;
            s_nxt.ack_drv = 1'b0;
        end else if (stop_c) begin
            s_nxt.st = st_idle;
            s_nxt.ack_drv = 1'b0;
        end else begin
            case (s_r.st)
                st_addr, st_rx: begin
                    if (scl_rise) begin
                        s_nxt.sh = {s_r.sh[6:0], sda_h};
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                    if (scl_fall && s_r.cnt == bit_cnt_last) begin
                        s_nxt.cnt = 4'h0;
                        if (s_r.st == st_addr) begin
                            if (s_r.sh[7:1] == dev_addr) begin
                                s_nxt.rd = s_r.sh[0];
                                s_nxt.ack_drv = 1'b1;
                                s_nxt.st = st_ack;
                            end else begin
                                s_nxt.st = st_idle;
                            end
                        end else begin
                            s_nxt.ack_drv = 1'b1;
                            s_nxt.st = st_ack;
                            if (!s_r.have_ptr) begin
                                s_nxt.ptr = s_r.sh;
                                s_nxt.have_ptr = 1'b1;
                            end else begin
                                // write lands in the register right away
                                if (s_r.ptr == addr_pin_config)
                                    s_nxt.pin_cfg = s_r.sh & pin_config_mask;
                                else if (s_r.ptr == addr_irq_enable)
                                    s_nxt.irq_en = s_r.sh;
                                else if (s_r.ptr == addr_pin_routing)
                                    s_nxt.routing = s_r.sh;
                                else if (s_r.ptr == addr_press_trim)
                                    s_nxt.p_trim = s_r.sh;
                                else if (s_r.ptr == addr_temp_trim)
                                    s_nxt.t_trim = s_r.sh;
                                else if (s_r.ptr == addr_alt_trim)
                                    s_nxt.a_trim = s_r.sh;
                                s_nxt.ptr = s_r.ptr + 8'h01;
                            end
                        end
                    end
                end
                st_ack: begin
                    if (scl_fall) begin
                        s_nxt.ack_drv = 1'b0;
                        if (s_r.rd) begin
                            s_nxt.sh = read_reg(s_r, s_r.ptr);
                            s_nxt.ptr = s_r.ptr + 8'h01;
                            s_nxt.st = st_tx;
                        end else begin
                            s_nxt.st = st_rx;
                        end
                    end
                end
                st_tx: begin
                    if (scl_fall) begin
                        s_nxt.sh = {s_r.sh[6:0], 1'b1};
                        s_nxt.cnt = s_r.cnt + 4'h1;
                        if (s_r.cnt == bit_cnt_last - 4'h1) begin
                            s_nxt.cnt = 4'h0;
                            s_nxt.st = st_mack;
                        end
                    end
                end
                st_mack: begin
                    if (scl_rise) s_nxt.rd = ~sda_h;
                    if (scl_fall) begin
                        if (s_r.rd) begin
                            s_nxt.sh = read_reg(s_r, s_r.ptr);
                            s_nxt.ptr = s_r.ptr + 8'h01;
                            s_nxt.st = st_tx;
                        end else begin
                            s_nxt.st = st_idle;
                        end
                    end
                end
                default: s_nxt.st = st_idle;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.scl_s <= 2'h3;
            s_r.sda_s <= 2'h3;
            s_r.scl_d <= 1'b1;
            s_r.sda_d <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sda_o  = 1'b0;
    assign sda_oe = s_r.ack_drv | (s_r.st == st_tx && !s_r.sh[7]);
    assign press_out = s_r.p_out;
    assign temp_out  = s_r.t_out;
    assign alt_out   = s_r.a_out;

    irq_pin_driver u_pin_a (
        .active     (s_r.pa),
        .polarity   (s_r.pin_cfg[bit_a_polarity]),
        .drive_kind (s_r.pin_cfg[bit_a_drive_kind]),
        .pin_o      (irq_pin_a_o),
        .pin_oe     (irq_pin_a_oe)
    );
    irq_pin_driver u_pin_b (
        .active     (s_r.pb),
        .polarity   (s_r.pin_cfg[bit_b_polarity]),
        .drive_kind (s_r.pin_cfg[bit_b_drive_kind]),
        .pin_o      (irq_pin_b_o),
        .pin_oe     (irq_pin_b_oe)
    );

    chk_route_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 s_r.pa == |($past(event_flags) & $past(s_r.irq_en) & $past(s_r.routing)))
        else $error("pin a routing wrong");
    chk_route_pin_b: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 s_r.pb == |($past(event_flags) & $past(s_r.irq_en) & ~$past(s_r.routing)))
        else $error("pin b routing wrong");
    chk_enable_gate: assert property (@(posedge clk) disable iff (!reset_n)
        (s_r.irq_en == 8'h00) |=> !s_r.pa && !s_r.pb)
        else $error("disabled source reached pin");
    chk_polarity_low: assert property (@(posedge clk) disable iff (!reset_n)
        (!s_r.pin_cfg[bit_a_polarity] && !s_r.pin_cfg[bit_a_drive_kind])
        |-> irq_pin_a_o == ~s_r.pa && irq_pin_a_oe)
        else $error("pin a polarity wrong");
    chk_open_drain: assert property (@(posedge clk) disable iff (!reset_n)
        s_r.pin_cfg[bit_b_drive_kind] |-> !irq_pin_b_o)
        else $error("open drain drove high");
    chk_press_trim: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 press_out == $past(press_raw)
        + press_width'($signed($past(s_r.p_trim)) * press_pa_per_lsb))
        else $error("pressure trim wrong");
    chk_temp_trim: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 temp_out == $past(temp_raw) + temp_width'($signed($past(s_r.t_trim))))
        else $error("temperature trim wrong");
    chk_alt_trim: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 alt_out == $past(alt_raw) + alt_width'($signed($past(s_r.a_trim))))
        else $error("altitude trim wrong");
    chk_trim_live: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(s_r.a_trim)
        |=> alt_out == $past(alt_raw) + alt_width'($signed($past(s_r.a_trim))))
        else $error("trim write not applied");
endmodule : irq_routing_offset_trim

// ==== test/i2c_host_model.sv ====
`timescale 1ns/1ps
module i2c_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    import irq_trim_pkg::*;
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // scl low and high four clocks each, sampled at the end of high
    task automatic phase(input logic c, input logic l, input int n);
        scl     <= c;
        sda_low <= l;
        repeat (n) @(posedge clk);
    endtask : phase
    task automatic xbit(input logic b, output logic s);
        @(posedge clk) phase(1'b0, !b, 3);
        phase(1'b1, !b, 4);
        s = sda;
        scl <= 1'b0;
    endtask : xbit
    task automatic start_cond;
        @(posedge clk) phase(scl, 1'b0, 3);
        phase(1'b1, 1'b0, 4);
        phase(1'b1, 1'b1, 4);
        scl <= 1'b0;
    endtask : start_cond
    task automatic stop_cond;
        @(posedge clk) phase(1'b0, 1'b1, 3);
        phase(1'b1, 1'b1, 4);
        phase(1'b1, 1'b0, 4);
    endtask : stop_cond
    task automatic xbyte(input logic [7:0] d, input logic fin, output logic [7:0] q,
                         output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], s);
            q[i] = s;
        end
        xbit(fin, s);
        ack = !s;
    endtask : xbyte
    task automatic write_regs(input logic [6:0] dev, input logic [7:0] ptr,
                              input logic [7:0] d[$], output logic ok);
        logic [7:0] q;
        logic       a;
        start_cond();
        xbyte({dev, 1'b0}, 1'b1, q, ok);
        xbyte(ptr, 1'b1, q, a);
        ok = ok & a;
        foreach (d[i]) begin
            xbyte(d[i], 1'b1, q, a);
            ok = ok & a;
        end
        stop_cond();
    endtask : write_regs
    task automatic read_regs(input logic [7:0] ptr, input int n, output logic [7:0] q[$]);
        logic [7:0] b;
        logic       a;
        q = {};
        start_cond();
        xbyte({dev_addr, 1'b0}, 1'b1, b, a);
        xbyte(ptr, 1'b1, b, a);
        start_cond();
        xbyte({dev_addr, 1'b1}, 1'b1, b, a);
        for (int i = 0; i < n; i++) begin
            xbyte(8'hff, i == n - 1, b, a);
            q.push_back(b);
        end
        stop_cond();
    endtask : read_regs
endmodule : i2c_host_model

// ==== test/tb_irq_routing_offset_trim.sv ====
`timescale 1ns/1ps
module tb_irq_routing_offset_trim;
    import irq_trim_pkg::*;
    logic        clk, reset_n, scl, host_low, sda, sda_o, sda_oe, ok;
    logic [7:0]  event_flags;
    logic [19:0] press_raw, alt_raw, press_out, alt_out;
    logic [11:0] temp_raw, temp_out;
    logic        pa_o, pa_oe, pb_o, pb_oe;
    logic [7:0]  d[$], q[$];
    int          mismatches, cmp_count, seed;
    int          regs_m [8];
    assign sda = !(host_low || (sda_oe && !sda_o));
    irq_routing_offset_trim uut (.clk(clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .event_flags(event_flags), .press_raw(press_raw),
        .temp_raw(temp_raw), .alt_raw(alt_raw), .press_out(press_out), .temp_out(temp_out),
        .alt_out(alt_out), .irq_pin_a_o(pa_o), .irq_pin_a_oe(pa_oe), .irq_pin_b_o(pb_o),
        .irq_pin_b_oe(pb_oe));
    i2c_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
    always #50 clk = ~clk;
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic int sx(int v);
        return (v ^ 128) - 128;
    endfunction : sx
    task automatic check_outputs;
        logic [7:0] c, r;
        int         act, lvl;
        c = 8'(regs_m[0]);
        for (int p = 0; p < 2; p++) begin
            r = 8'(regs_m[2]);
            if (p == 1) r = ~r;
            act = (event_flags & 8'(regs_m[1]) & r) != 0;
            lvl = c[p == 0 ? 5 : 1] ? act : !act;
            if (c[p == 0 ? 4 : 0]) begin
                check("pin_o", p == 0 ? pa_o : pb_o, 0);
                check("pin_oe", p == 0 ? pa_oe : pb_oe, 32'(!lvl));
            end else begin
                check("pin_o", p == 0 ? pa_o : pb_o, 32'(lvl));
                check("pin_oe", p == 0 ? pa_oe : pb_oe, 1);
            end
        end
        check("press", press_out, (press_raw + sx(regs_m[3]) * 4) & 'hfffff);
        check("temp", temp_out, (temp_raw + sx(regs_m[4])) & 'hfff);
        check("alt", alt_out, (alt_raw + sx(regs_m[5])) & 'hfffff);
        check("sda_o", sda_o, 0);
    endtask : check_outputs
    task automatic check_regs;
        host.read_regs(addr_pin_config, 8, q);
        foreach (q[k]) check("reg", q[k], regs_m[k]);
    endtask : check_regs
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        summarize();
    end
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {event_flags, press_raw, temp_raw, alt_raw} = '0;
        seed = $urandom(46);
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        check_outputs();
        check_regs();
        // wrong device address is ignored
        d = {8'hff};
        host.write_regs(7'h61, addr_pin_routing, d, ok);
        check("ack", ok, 0);
        check_regs();
        for (int it = 0; it < 12; it++) begin
            d = {};
            for (int k = 0; k < 8; k++) begin
                d.push_back(8'($urandom));
                if (k < 6) regs_m[k] = d[k] & (k == 0 ? pin_config_mask : 8'hff);
            end
            host.write_regs(dev_addr, addr_pin_config, d, ok);
            check("ack", ok, 1);
            repeat (4) begin
                @(posedge clk);
                event_flags <= 8'($urandom);
                press_raw <= 20'($urandom);
                temp_raw <= 12'($urandom);
                alt_raw <= 20'($urandom);
                repeat (3) @(posedge clk);
                check_outputs();
            end
            // host reads the registers back after the pins have fired
            check_regs();
        end
        summarize();
    end
endmodule : tb_irq_routing_offset_trim
